/* hdl/gffb_map.svh */
// offsets, field positions, reset values and timing counts of the forced-function block
`ifndef GFFB_MAP_SVH
`define GFFB_MAP_SVH
// ==========================================================
// register offsets (byte addresses)
`define GFFB_DBGCFG_OFS 8'h00
`define GFFB_DBGSTAT_OFS 8'h04
`define GFFB_PACFG_OFS 8'h08
`define GFFB_PCCFG_OFS 8'h0C
`define GFFB_PAOUT_OFS 8'h10
`define GFFB_PCOUT_OFS 8'h14
`define GFFB_CTRL_OFS 8'h18
// ==========================================================
// field positions
`define GFFB_DBGCFG_DEBUGREL 5
`define GFFB_DBGCFG_REGOVR 4
`define GFFB_DBGSTAT_BOOTCAP 3
`define GFFB_DBGSTAT_FORCED 1
`define GFFB_DBGSTAT_DBGACT 0
`define GFFB_CTRL_MONEXIT 0
// ==========================================================
// reset values and mode codes
`define GFFB_CFG_RESET 32'h44444444
`define GFFB_MODE_ANALOG 4'h0
`define GFFB_MODE_IN_FLOAT 4'h4
`define GFFB_MODE_IN_PULL 4'h8
`define GFFB_MODE_OUT_PP 4'h1
`define GFFB_MODE_OUT_OD 4'h5
`define GFFB_MODE_ALT_PP 4'h9
`define GFFB_MODE_ALT_OD 4'hD
// ==========================================================
// timing
`define GFFB_CLK_HZ 100000000
`define GFFB_STARTUP_CYCLES 512
`define GFFB_RESAMPLE_MS 3
`define GFFB_RESAMPLE_CYCLES ((`GFFB_RESAMPLE_MS * `GFFB_CLK_HZ) / 1000)
`endif

/* hdl/gffb_pkg.sv */
// types shared by the forced-function block
package gffb_pkg;
   // boot sequencer states
   typedef enum logic [2:0] {
      GFFB_ST_STARTUP,
      GFFB_ST_SAMPLE,
      GFFB_ST_MONITOR,
      GFFB_ST_NORMAL,
      GFFB_ST_BOOT_MON
   } gffb_boot_t;
endpackage

/* hdl/gffb_pad_mux.sv */
// one pad: configured mode decode with forced override
`timescale 1ns/1ps
`default_nettype none
`include "gffb_map.svh"
module gffb_pad_mux (
   input wire logic [3:0] i_mode,   // configured mode field
   input wire logic i_out_bit,      // output data register bit
   input wire logic i_alt_out,      // peripheral alternate output
   input wire logic i_force,        // override active
   input wire logic i_f_oe,         // forced drive enable
   input wire logic i_f_out,        // forced output level
   input wire logic i_f_pu,         // forced pull-up
   input wire logic i_f_pd,         // forced pull-down
   output logic o_oe,               // pad driven
   output logic o_out,              // pad output level
   output logic o_pu,               // pull-up enable
   output logic o_pd                // pull-down enable
);
   logic c_oe;
   logic c_out;
   logic c_pu;
   logic c_pd;
   // decode of the configured mode; open-drain drives only a low
   always_comb begin
      c_oe = 1'b0;
      c_out = 1'b0;
      c_pu = 1'b0;
      c_pd = 1'b0;
      case (i_mode)
         `GFFB_MODE_IN_PULL: begin
            c_pu = i_out_bit;
            c_pd = ~i_out_bit;
         end
         `GFFB_MODE_OUT_PP: begin
            c_oe = 1'b1;
            c_out = i_out_bit;
         end
         `GFFB_MODE_OUT_OD: begin
            c_oe = ~i_out_bit;
         end
         `GFFB_MODE_ALT_PP: begin
            c_oe = 1'b1;
            c_out = i_alt_out;
         end
         `GFFB_MODE_ALT_OD: begin
            c_oe = ~i_alt_out;
         end
         default: begin
            c_oe = 1'b0;
         end
      endcase
   end
   // forced function wins over the configured mode
   assign o_oe = i_force ? i_f_oe : c_oe;
   assign o_out = i_force ? i_f_out : c_out;
   assign o_pu = i_force ? i_f_pu : c_pu;
   assign o_pd = i_force ? i_f_pd : c_pd;
endmodule
`default_nettype wire

/* hdl/gffb_wb_regs.sv */
// classic wishbone slave holding configuration and status registers
`timescale 1ns/1ps
`default_nettype none
`include "gffb_map.svh"
module gffb_wb_regs (
   input wire logic i_ref_clk,         // clock
   input wire logic i_rst,             // async reset, high
   input wire logic i_cyc,             // wishbone cycle
   input wire logic i_stb,             // wishbone strobe
   input wire logic i_we,              // wishbone write
   input wire logic [7:0] i_adr,       // byte address
   input wire logic [3:0] i_sel,       // byte selects
   input wire logic [31:0] i_dat,      // write data
   input wire logic i_dbg_active,      // debug power-up request
   input wire logic i_forced,          // debug forced flag
   input wire logic i_boot_cap,        // captured boot-select level
   output logic [31:0] o_dat,          // read data
   output logic o_ack,                 // acknowledge
   output logic o_err,                 // unmapped address
   output logic o_reg_ovr,             // regulator override bit
   output logic o_dbg_rel,             // debug release bit
   output logic [31:0] o_pa_cfg,       // port a mode fields
   output logic [31:0] o_pc_cfg,       // port c mode fields
   output logic [7:0] o_pa_out,        // port a output data
   output logic [7:0] o_pc_out,        // port c output data
   output logic o_mon_exit_pulse       // software leaves the monitor
);
   logic req;
   logic wr;
   logic hit;
   logic [31:0] rd;
   logic [31:0] wmask;
   genvar g;
   assign req = i_cyc & i_stb & ~o_ack & ~o_err;
   assign wr = req & i_we & hit;
   // byte lane mask from selects
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_mask
         assign wmask[8*g+7:8*g] = {8{i_sel[g]}};
      end
   endgenerate
   // merge masked write data into an old value
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
      merge = (old & ~m) | (nw & m);
   endfunction
   // address decode and read mux
   always_comb begin
      hit = 1'b1;
      rd = 32'h00000000;
      case (i_adr)
         `GFFB_DBGCFG_OFS: begin
            rd[`GFFB_DBGCFG_DEBUGREL] = o_dbg_rel;
            rd[`GFFB_DBGCFG_REGOVR] = o_reg_ovr;
         end
         `GFFB_DBGSTAT_OFS: begin
            rd[`GFFB_DBGSTAT_BOOTCAP] = i_boot_cap;
            rd[`GFFB_DBGSTAT_FORCED] = i_forced;
            rd[`GFFB_DBGSTAT_DBGACT] = i_dbg_active;
         end
         `GFFB_PACFG_OFS: rd = o_pa_cfg;
         `GFFB_PCCFG_OFS: rd = o_pc_cfg;
         `GFFB_PAOUT_OFS: rd = {24'h000000, o_pa_out};
         `GFFB_PCOUT_OFS: rd = {24'h000000, o_pc_out};
         `GFFB_CTRL_OFS: rd = 32'h00000000;
         default: hit = 1'b0;
      endcase
   end
   // answer one cycle after the request, then drop
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_ack <= 1'b0;
         o_err <= 1'b0;
         o_dat <= 32'h00000000;
      end else begin
         o_ack <= req & hit;
         o_err <= req & ~hit;
         o_dat <= (req & hit & ~i_we) ? rd : 32'h00000000;
      end
   end
   // debug configuration bits
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_reg_ovr <= 1'b1;
         o_dbg_rel <= 1'b0;
      end else if (wr && i_adr == `GFFB_DBGCFG_OFS && i_sel[0]) begin
         o_reg_ovr <= i_dat[`GFFB_DBGCFG_REGOVR];
         // a set is refused while the debug port is powered
         if (!(i_dat[`GFFB_DBGCFG_DEBUGREL] && i_dbg_active)) begin
            o_dbg_rel <= i_dat[`GFFB_DBGCFG_DEBUGREL];
         end
      end
   end
   // mode fields reset to floating input
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_pa_cfg <= `GFFB_CFG_RESET;
         o_pc_cfg <= `GFFB_CFG_RESET;
      end else if (wr && i_adr == `GFFB_PACFG_OFS) begin
         o_pa_cfg <= merge(o_pa_cfg, i_dat, wmask);
      end else if (wr && i_adr == `GFFB_PCCFG_OFS) begin
         o_pc_cfg <= merge(o_pc_cfg, i_dat, wmask);
      end
   end
   // output data registers
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_pa_out <= 8'h00;
         o_pc_out <= 8'h00;
      end else if (wr && i_adr == `GFFB_PAOUT_OFS && i_sel[0]) begin
         o_pa_out <= i_dat[7:0];
      end else if (wr && i_adr == `GFFB_PCOUT_OFS && i_sel[0]) begin
         o_pc_out <= i_dat[7:0];
      end
   end
   // monitor exit strobe
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_mon_exit_pulse <= 1'b0;
      end else begin
         o_mon_exit_pulse <= wr && i_adr == `GFFB_CTRL_OFS && i_sel[0] && i_dat[`GFFB_CTRL_MONEXIT];
      end
   end
endmodule
`default_nettype wire

/* hdl/gffb_top.sv */
// forced pin functions, debug pin release and boot-select sampling
// Function
// - forced functions apply from reset over mode fields until software releases them; the boot sequencer releases port a pin 5 after sampling.
// - regulator override set drives port a pin 7 open-drain with regulator enable.
// - clearing regulator override returns port a pin 7 to its mode field.
// - after reset debug pins are jtag: pin0 reset in, pin2 data out, pin3 in.
// - serial-wire mode makes port c pin 4 a debugger-controlled bidirectional data pin.
// - jtag mode makes port c pin 4 mode-select input with pull-up, tool chooses.
// - only the external tool switches jtag versus serial-wire; software cannot.
// - debug release set makes port c pins 0,2,3,4 ordinary mode-controlled pins.
// - setting debug release is ignored while the debug interface is active.
// - debug activated during reset restores debug pins and sets debug forced flag.
// - debug active means the tool drove the debug power-up request high.
// - power-on, reset pin, watchdog and system reset request are all full resets.
// - full reset sets every pin mode field to floating input.
// - full reset sets the regulator override bit.
// - full reset clears the debug release bit.
// - boot select acts only after reset pin or always-on power-on reset; the code also arms it after i_rst.
// - during reset and 512 startup cycles port a pin 5 is input with pull-up.
// - at startup end sample boot select: high normal boot, low serial monitor.
// - in monitor resample 3 ms later; still low stays, else normal program.
// - after sampling port a pin 5 returns to floating input control.
// - sampled boot-select level is latched into a readable capture bit.
// - floating input mode is field value 0x4, no output, no pulls.
//
// Register access over Wishbone and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "gffb_map.svh"
module gffb_top #(
   parameter int RESAMPLE_CYCLES = `GFFB_RESAMPLE_CYCLES
) (
   input wire logic i_ref_clk,            // 100 MHz clock
   input wire logic i_rst,                // async reset, high
   input wire logic i_por_lv,             // core power-on reset
   input wire logic i_always_on_power_on_reset,             // always-on power-on reset
   input wire logic i_ext_rst_pin,        // external reset pin asserted
   input wire logic i_wdog_rst,           // watchdog expiry
   input wire logic i_sys_rst_req,        // system reset request
   input wire logic i_wb_cyc,             // wishbone cycle
   input wire logic i_wb_stb,             // wishbone strobe
   input wire logic i_wb_we,              // wishbone write
   input wire logic [7:0] i_wb_adr,       // wishbone byte address
   input wire logic [3:0] i_wb_sel,       // wishbone byte selects
   input wire logic [31:0] i_wb_dat,      // wishbone write data
   output logic [31:0] o_wb_dat,          // wishbone read data
   output logic o_wb_ack,                 // wishbone ack
   output logic o_wb_err,                 // wishbone error
   input wire logic i_dbg_pwrup_req,      // debug power-up request from tool
   input wire logic i_dbg_swd_mode,       // tool selected serial-wire mode
   input wire logic i_swdio_oe,           // debugger drives data pin
   input wire logic i_swdio_out,          // debugger data out
   input wire logic i_tdo,                // test data output from tap
   input wire logic i_reg_en,             // regulator enable signal
   input wire logic [7:0] i_pa_alt,       // port a peripheral outputs
   input wire logic [7:0] i_pc_alt,       // port c peripheral outputs
   input wire logic [7:0] i_pa_pin,       // port a pad levels
   input wire logic [7:0] i_pc_pin,       // port c pad levels
   output logic [7:0] o_pa_oe,            // port a drive enables
   output logic [7:0] o_pa_out,           // port a output levels
   output logic [7:0] o_pa_pu,            // port a pull-ups
   output logic [7:0] o_pa_pd,            // port a pull-downs
   output logic [7:0] o_pc_oe,            // port c drive enables
   output logic [7:0] o_pc_out,           // port c output levels
   output logic [7:0] o_pc_pu,            // port c pull-ups
   output logic [7:0] o_pc_pd,            // port c pull-downs
   output logic o_boot_monitor,           // running the serial monitor
   output logic o_boot_done,              // boot decision made
   output logic o_dbg_forced              // debug forced flag
);
   // ==========================================================
   // reset sources
   logic full_rst;
   logic bootsel_rst;
   assign full_rst = i_rst | i_por_lv | i_always_on_power_on_reset | i_ext_rst_pin | i_wdog_rst | i_sys_rst_req;
   assign bootsel_rst = i_ext_rst_pin | i_always_on_power_on_reset;
   // ==========================================================
   // register file
   logic reg_ovr;
   logic dbg_rel;
   logic [31:0] pa_cfg;
   logic [31:0] pc_cfg;
   logic [7:0] pa_obit;
   logic [7:0] pc_obit;
   logic mon_exit;
   logic boot_cap_reg;
   logic dbg_active;
   assign dbg_active = i_dbg_pwrup_req;
   gffb_wb_regs u_regs (
      .i_ref_clk(i_ref_clk),
      .i_rst(full_rst),
      .i_cyc(i_wb_cyc),
      .i_stb(i_wb_stb),
      .i_we(i_wb_we),
      .i_adr(i_wb_adr),
      .i_sel(i_wb_sel),
      .i_dat(i_wb_dat),
      .i_dbg_active(dbg_active),
      .i_forced(o_dbg_forced),
      .i_boot_cap(boot_cap_reg),
      .o_dat(o_wb_dat),
      .o_ack(o_wb_ack),
      .o_err(o_wb_err),
      .o_reg_ovr(reg_ovr),
      .o_dbg_rel(dbg_rel),
      .o_pa_cfg(pa_cfg),
      .o_pc_cfg(pc_cfg),
      .o_pa_out(pa_obit),
      .o_pc_out(pc_obit),
      .o_mon_exit_pulse(mon_exit)
   );
   // ==========================================================
   // debug forced flag: debugger powered up while chip held in reset
   logic rst_seen_dbg;
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         rst_seen_dbg <= 1'b0;
      end else if (full_rst) begin
         rst_seen_dbg <= dbg_active;
      end else begin
         rst_seen_dbg <= 1'b0;
      end
   end
   // latched until a reset taken with the debug power-up request low; debugger-forced reclaim overrides release
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_dbg_forced <= 1'b0;
      end else if (rst_seen_dbg && !full_rst) begin
         o_dbg_forced <= 1'b1;
      end else if (full_rst && !dbg_active) begin
         o_dbg_forced <= 1'b0;
      end
   end
   // ==========================================================
   // boot-select sequencer
   gffb_pkg::gffb_boot_t boot_state;
   logic [9:0] start_cnt;
   logic [31:0] res_cnt;
   logic boot_armed;
   // remember whether the last reset was one that honours boot select
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         boot_armed <= 1'b1;
      end else if (full_rst) begin
         boot_armed <= bootsel_rst;
      end
   end
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         boot_state <= gffb_pkg::GFFB_ST_STARTUP;
         start_cnt <= 10'h000;
         res_cnt <= 32'h00000000;
         boot_cap_reg <= 1'b1;
      end else if (full_rst) begin
         boot_state <= gffb_pkg::GFFB_ST_STARTUP;
         start_cnt <= 10'h000;
         res_cnt <= 32'h00000000;
      end else begin
         case (boot_state)
            gffb_pkg::GFFB_ST_STARTUP: begin
               if (start_cnt == 10'(`GFFB_STARTUP_CYCLES - 1)) begin
                  boot_state <= gffb_pkg::GFFB_ST_SAMPLE;
               end else begin
                  start_cnt <= start_cnt + 10'h001;
               end
            end
            gffb_pkg::GFFB_ST_SAMPLE: begin
               if (boot_armed) begin
                  boot_cap_reg <= i_pa_pin[5];
                  boot_state <= i_pa_pin[5] ? gffb_pkg::GFFB_ST_NORMAL : gffb_pkg::GFFB_ST_MONITOR;
               end else begin
                  boot_state <= gffb_pkg::GFFB_ST_NORMAL;
               end
            end
            gffb_pkg::GFFB_ST_MONITOR: begin
               if (mon_exit) begin
                  boot_state <= gffb_pkg::GFFB_ST_NORMAL;
               end else if (res_cnt == 32'(RESAMPLE_CYCLES - 1)) begin
                  boot_state <= i_pa_pin[5] ? gffb_pkg::GFFB_ST_NORMAL : gffb_pkg::GFFB_ST_BOOT_MON;
               end else begin
                  res_cnt <= res_cnt + 32'h00000001;
               end
            end
            gffb_pkg::GFFB_ST_NORMAL: begin
               boot_state <= gffb_pkg::GFFB_ST_NORMAL;
            end
            gffb_pkg::GFFB_ST_BOOT_MON: begin
               if (mon_exit) begin
                  boot_state <= gffb_pkg::GFFB_ST_NORMAL;
               end
            end
            default: begin
               boot_state <= gffb_pkg::GFFB_ST_STARTUP;
            end
         endcase
      end
   end
   assign o_boot_monitor = (boot_state == gffb_pkg::GFFB_ST_MONITOR) || (boot_state == gffb_pkg::GFFB_ST_BOOT_MON);
   assign o_boot_done = (boot_state == gffb_pkg::GFFB_ST_NORMAL) || (boot_state == gffb_pkg::GFFB_ST_BOOT_MON);
   // ==========================================================
   // forced function selection per pin
   logic boot_hold;
   logic dbg_force;
   logic [7:0] pa_force;
   logic [7:0] pc_force;
   logic [7:0] pa_foe;
   logic [7:0] pa_fout;
   logic [7:0] pa_fpu;
   logic [7:0] pc_foe;
   logic [7:0] pc_fout;
   logic [7:0] pc_fpu;
   // pull-up hold on the boot pin until sampled, then floating input mode applies
   assign boot_hold = full_rst || (boot_state == gffb_pkg::GFFB_ST_STARTUP) || (boot_state == gffb_pkg::GFFB_ST_SAMPLE);
   // debug pins forced unless released, forced-reclaim beats release
   assign dbg_force = ~dbg_rel | o_dbg_forced | full_rst;
   always_comb begin
      pa_force = 8'h00;
      pa_foe = 8'h00;
      pa_fout = 8'h00;
      pa_fpu = 8'h00;
      pc_force = 8'h00;
      pc_foe = 8'h00;
      pc_fout = 8'h00;
      pc_fpu = 8'h00;
      // regulator enable, open-drain: drive only a low
      pa_force[7] = reg_ovr | full_rst;
      pa_foe[7] = ~i_reg_en;
      pa_force[5] = boot_hold;
      pa_fpu[5] = 1'b1;
      // jtag pins
      pc_force[0] = dbg_force;
      pc_fpu[0] = 1'b1;
      pc_force[2] = dbg_force;
      pc_foe[2] = 1'b1;
      pc_fout[2] = i_tdo;
      pc_force[3] = dbg_force;
      pc_fpu[3] = 1'b1;
      // mode of pin 4 comes from the tool only, no software bit
      pc_force[4] = dbg_force;
      if (i_dbg_swd_mode) begin
         pc_foe[4] = i_swdio_oe;
         pc_fout[4] = i_swdio_out;
      end else begin
         pc_fpu[4] = 1'b1;
      end
   end
   // ==========================================================
   // pad multiplexers
   genvar p;
   generate
      for (p = 0; p < 8; p = p + 1) begin : g_pad
         gffb_pad_mux u_pa (
            .i_mode(pa_cfg[4*p+3:4*p]),
            .i_out_bit(pa_obit[p]),
            .i_alt_out(i_pa_alt[p]),
            .i_force(pa_force[p]),
            .i_f_oe(pa_foe[p]),
            .i_f_out(pa_fout[p]),
            .i_f_pu(pa_fpu[p]),
            .i_f_pd(1'b0),
            .o_oe(o_pa_oe[p]),
            .o_out(o_pa_out[p]),
            .o_pu(o_pa_pu[p]),
            .o_pd(o_pa_pd[p])
         );
         gffb_pad_mux u_pc (
            .i_mode(pc_cfg[4*p+3:4*p]),
            .i_out_bit(pc_obit[p]),
            .i_alt_out(i_pc_alt[p]),
            .i_force(pc_force[p]),
            .i_f_oe(pc_foe[p]),
            .i_f_out(pc_fout[p]),
            .i_f_pu(pc_fpu[p]),
            .i_f_pd(1'b0),
            .o_oe(o_pc_oe[p]),
            .o_out(o_pc_out[p]),
            .o_pu(o_pc_pu[p]),
            .o_pd(o_pc_pd[p])
         );
      end
   endgenerate
endmodule
`default_nettype wire

/* test/gffb_checker.sv */
// assertions on the forced-function block ports
`timescale 1ns/1ps
`default_nettype none
module gffb_checker #(
   parameter int RESAMPLE_CYCLES = 20
) (
   input wire logic i_ref_clk, // clock
   input wire logic i_rst, // reset
   input wire logic i_wb_cyc, // cycle
   input wire logic i_wb_stb, // strobe
   input wire logic o_wb_ack, // ack
   input wire logic o_wb_err, // error
   input wire logic i_reg_en, // regulator enable
   input wire logic i_dbg_swd_mode, // serial-wire mode
   input wire logic [7:0] o_pa_oe, // port a drive
   input wire logic [7:0] o_pa_pu, // port a pull-ups
   input wire logic [7:0] o_pc_oe, // port c drive
   input wire logic [7:0] o_pc_pu, // port c pull-ups
   input wire logic o_boot_monitor, // monitor
   input wire logic o_boot_done // boot decided
);
   localparam int RS_MAX = RESAMPLE_CYCLES + 4;
   logic [9:0] up_cnt;
   // ==========
   // cycles since reset release, saturating
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         up_cnt <= 10'h000;
      end else if (up_cnt != 10'h3FF) begin
         up_cnt <= up_cnt + 10'h001;
      end
   end
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   wb_answer_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack && !o_wb_err |=> o_wb_ack ^ o_wb_err)
      else $error("wishbone answer missing");
   ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack longer than one cycle");
   reg_pin_a: assert property ($fell(i_rst) |-> o_pa_oe[7] == !i_reg_en)
      else $error("regulator pin not forced");
   jtag_pins_a: assert property ($fell(i_rst) && !i_dbg_swd_mode |->
      o_pc_pu[0] && o_pc_pu[3] && o_pc_pu[4] && o_pc_oe[2] && !o_pc_oe[0]) else $error("debug pins not forced");
   float_pin_a: assert property ($fell(i_rst) |-> !o_pa_oe[6] && !o_pa_pu[6])
      else $error("pin not floating");
   boot_pull_a: assert property (!o_boot_done && !o_boot_monitor |-> o_pa_pu[5])
      else $error("boot pin pull-up missing");
   startup_hold_a: assert property (up_cnt < 10'h201 |-> !o_boot_done && !o_boot_monitor)
      else $error("boot decided early");
   startup_end_a: assert property (up_cnt == 10'h201 |-> o_boot_done || o_boot_monitor)
      else $error("boot not decided");
   resample_by_a: assert property ($rose(o_boot_monitor) |-> !o_boot_done ##[1:RS_MAX] o_boot_done)
      else $error("resample late");
endmodule
bind gffb_top gffb_checker #(.RESAMPLE_CYCLES(RESAMPLE_CYCLES)) chk_u (.i_ref_clk, .i_rst, .i_wb_cyc, .i_wb_stb,
   .o_wb_ack, .o_wb_err, .i_reg_en, .i_dbg_swd_mode, .o_pa_oe, .o_pa_pu, .o_pc_oe, .o_pc_pu, .o_boot_monitor,
   .o_boot_done);
`default_nettype wire

/* test/gffb_far_side.sv */
// far side: debug tool, external regulator, boot-select driver
`timescale 1ns/1ps
`default_nettype none
module gffb_far_side (
   input wire logic i_ref_clk, // clock
   input wire logic i_boot_low, // hold boot select low
   input wire logic i_dbg_on, // tool powers debug up
   input wire logic i_swd_on, // tool selects serial-wire
   output logic o_pwrup_req, // debug power-up request
   output logic o_swd_mode, // serial-wire selected
   output logic o_reg_en, // regulator enable
   output logic o_boot_pin // boot-select level
);
   initial begin
      o_pwrup_req = 1'b0;
      o_swd_mode = 1'b0;
      o_reg_en = 1'b0;
      o_boot_pin = 1'b0;
   end
   // tool picks the port mode, regulator enable toggles
   always @(posedge i_ref_clk) begin
      o_pwrup_req <= i_dbg_on;
      o_swd_mode <= i_swd_on;
      o_reg_en <= ~o_reg_en;
      o_boot_pin <= ~i_boot_low;
   end
endmodule
`default_nettype wire

/* test/gpio_forced_function_boot_test.sv */
// self-checking bench of the forced-function block
`timescale 1ns/1ps
`default_nettype none
module gpio_forced_function_boot_test;
   logic i_ref_clk = 1'b0, i_rst = 1'b1, i_wdog_rst = 1'b0, tog = 1'b0, boot_low = 1'b1, dbg_on = 1'b0;
   logic i_ext_rst_pin = 1'b0, swd_on = 1'b0;
   logic i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0, boot_pin, i_dbg_pwrup_req, i_dbg_swd_mode, i_reg_en;
   logic [7:0] i_wb_adr = 8'h00;
   logic [31:0] i_wb_dat = 32'h0, o_wb_dat, rd;
   logic o_wb_ack, o_wb_err, o_boot_monitor, o_boot_done, o_dbg_forced;
   logic [7:0] i_pa_pin, o_pa_oe, o_pa_out, o_pa_pu, o_pc_oe, o_pc_pu;
   int mismatches = 0, n_checks = 0, cyc_cnt = 0, n;
   assign i_pa_pin = {2'h3, boot_pin, 5'h1F};
   gffb_top #(.RESAMPLE_CYCLES(20)) dut_u (.i_ref_clk, .i_rst, .i_por_lv(1'b0), .i_always_on_power_on_reset(1'b0),
      .i_ext_rst_pin, .i_wdog_rst, .i_sys_rst_req(1'b0), .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
      .i_wb_sel(4'hF), .i_wb_dat, .o_wb_dat, .o_wb_ack, .o_wb_err, .i_dbg_pwrup_req, .i_dbg_swd_mode,
      .i_swdio_oe(tog), .i_swdio_out(tog), .i_tdo(tog), .i_reg_en, .i_pa_alt({8{tog}}), .i_pc_alt({8{~tog}}),
      .i_pa_pin, .i_pc_pin(8'hFF), .o_pa_oe, .o_pa_out, .o_pa_pu, .o_pa_pd(), .o_pc_oe, .o_pc_out(), .o_pc_pu,
      .o_pc_pd(), .o_boot_monitor, .o_boot_done, .o_dbg_forced);
   gffb_far_side far_u (.i_ref_clk, .i_boot_low(boot_low), .i_dbg_on(dbg_on), .o_pwrup_req(i_dbg_pwrup_req),
      .i_swd_on(swd_on), .o_swd_mode(i_dbg_swd_mode), .o_reg_en(i_reg_en), .o_boot_pin(boot_pin));
   initial begin
      forever #5 i_ref_clk = ~i_ref_clk;
   end
   // cycle ceiling and toggling stimulus
   always @(posedge i_ref_clk) begin
      tog <= ~tog;
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         mismatches++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // one classic wishbone cycle, answer taken at the ack edge
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
      i_wb_cyc <= 1'b1;
      i_wb_stb <= 1'b1;
      i_wb_we <= we;
      i_wb_adr <= adr;
      i_wb_dat <= wd;
      n = 0;
      do begin
         @(posedge i_ref_clk);
         n++;
      end while (o_wb_ack !== 1'b1 && o_wb_err !== 1'b1);
      rd = o_wb_err ? 32'hEEEEEEEE : o_wb_dat;
      i_wb_cyc <= 1'b0;
      i_wb_stb <= 1'b0;
      @(posedge i_ref_clk);
   endtask
   task automatic wait_on(input int lim);
      repeat (lim) @(posedge i_ref_clk);
   endtask
   initial begin
      wait_on(10);
      i_rst <= 1'b0;
      @(posedge i_ref_clk);
      wb(1'b0, 8'h08, 32'h0); chk("pa_cfg", 32'h44444444, rd);
      wb(1'b0, 8'h00, 32'h0); chk("dbg_cfg", 32'h10, rd & 32'h30);
      for (n = 0; n < 2000 && o_boot_monitor !== 1'b1; n++) @(posedge i_ref_clk);
      chk("boot_pin_pull", 32'h0, o_pa_pu[5]);
      wb(1'b0, 8'h04, 32'h0); chk("boot_cap", 32'h0, rd[3]);
      boot_low <= 1'b0;
      wait_on(40); chk("mon_left", 32'h2, {o_boot_done, o_boot_monitor});
      dbg_on <= 1'b1;
      wait_on(3);
      wb(1'b1, 8'h00, 32'h30); wb(1'b0, 8'h00, 32'h0); chk("rel_ignored", 32'h10, rd & 32'h30);
      dbg_on <= 1'b0;
      wait_on(3);
      wb(1'b1, 8'h00, 32'h20); chk("released", 32'h0, {o_pc_pu[0], o_pc_oe[2], o_pa_oe[7]});
      wb(1'b1, 8'h08, 32'h14444444); wb(1'b1, 8'h10, 32'h80); chk("reg_pin_out", 32'h3, {o_pa_oe[7], o_pa_out[7]});
      dbg_on <= 1'b1;
      wait_on(2);
      i_wdog_rst <= 1'b1;
      wait_on(3);
      i_wdog_rst <= 1'b0;
      wait_on(4); chk("dbg_forced", 32'h3, {o_dbg_forced, o_pc_pu[0]});
      swd_on <= 1'b1; wait_on(2); chk("swd_pin", {tog, 1'b0}, {o_pc_oe[4], o_pc_pu[4]});
      wb(1'b0, 8'h08, 32'h0); chk("wdog_cfg", 32'h44444444, rd);
      dbg_on <= 1'b0; wait_on(3); wb(1'b1, 8'h00, 32'h20); chk("reclaim_wins", 32'h1, o_pc_pu[0]);
      for (n = 0; n < 2000 && o_boot_done !== 1'b1; n++) @(posedge i_ref_clk);
      wb(1'b0, 8'h04, 32'h0); chk("cap_kept", 32'h1, {o_boot_monitor, rd[3], rd[1]});
      boot_low <= 1'b1; i_ext_rst_pin <= 1'b1; wait_on(3); i_ext_rst_pin <= 1'b0; wait_on(2);
      for (n = 0; n < 2000 && o_boot_monitor !== 1'b1; n++) @(posedge i_ref_clk);
      chk("pin_rst_mon", 32'h1, o_boot_monitor);
      wb(1'b1, 8'h18, 32'h1); chk("mon_exit", 32'h2, {o_boot_done, o_boot_monitor});
      wb(1'b0, 8'h40, 32'h0); chk("unmapped", 32'hEEEEEEEE, rd);
      end_sim();
   end
endmodule
`default_nettype wire
